// ===== iod_map.vh
// Purpose: Shared constants for the indexed operand address decoder.
// Assumes: 12-bit data address space, 4-bit bank number, 8-bit file field.
// Notes: Definitions only; included by bare name.
`ifndef IOD_MAP_VH
`define IOD_MAP_VH

// ****************************************************************
// Address layout
// ****************************************************************
`define IOD_ADDR_W 12
`define IOD_FILE_W 8
`define IOD_BANK_W 4
`define IOD_INDEX_LIMIT 8'h5F
`define IOD_ACCESS_LOW_BASE 12'h000
`define IOD_ACCESS_HIGH_BASE 12'hF00

// ****************************************************************
// Extended instruction group
// ****************************************************************
`define IOD_EXT_OP_COUNT 8
`define IOD_EXT_CODE_W 3

// ****************************************************************
// Reset values
// ****************************************************************
`define IOD_RST_ADDR 12'h000
`define IOD_RST_EXT_ON 1'b0
`define IOD_RST_SEL 8'h00

`endif

// ===== iod_addr_gen.v
// Purpose: Combinational data address for one byte or bit operand.
// Assumes: Inputs are stable within the core clock cycle.
// Notes: No state; the parent registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "iod_map.vh"

module iod_addr_gen (
  input wire ext_on,
  input wire access_sel,
  input wire [7:0] file_field,
  input wire [3:0] bank_select_register,
  input wire [11:0] stack_frame_pointer,
  output reg [11:0] addr,
  output reg indexed,
  output reg is_access
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function in_index_range;
    input [7:0] f;
    begin
      in_index_range = (f <= `IOD_INDEX_LIMIT);
    end
  endfunction

  function [11:0] access_addr;
    input [7:0] f;
    begin
      if (in_index_range(f)) begin
        access_addr = `IOD_ACCESS_LOW_BASE | {4'h0, f};
      end else begin
        access_addr = `IOD_ACCESS_HIGH_BASE | {4'h0, f};
      end
    end
  endfunction

  // ****************************************************************
  // Address select
  // ****************************************************************
  // The sum wraps in the 12-bit space; a zero pointer gives the
  // plain low Access RAM location.
  always @* begin
    addr = `IOD_RST_ADDR;
    indexed = 1'b0;
    is_access = 1'b0;
    if (access_sel) begin
      addr = {bank_select_register, file_field};
    end else if (ext_on && in_index_range(file_field)) begin
      addr = stack_frame_pointer + {4'h0, file_field};
      indexed = 1'b1;
    end else begin
      addr = access_addr(file_field);
      is_access = 1'b1;
    end
  end

endmodule // iod_addr_gen
`default_nettype wire

// ===== iod_operand_decode.v
// Purpose: Operand address generation for byte and bit instructions.
// Assumes: Decoder fields come from logic on core_clk; the extension
//   strap is a static configuration level.
// Notes: One cycle from request to registered address.
`timescale 1ns/1ps
`default_nettype none
`include "iod_map.vh"

module iod_operand_decode (
  input wire core_clk,
  input wire sys_rst,
  input wire ext_set_strap,
  input wire dec_valid,
  input wire dec_has_access,
  input wire [7:0] file_field,
  input wire access_sel,
  input wire dest_sel,
  input wire [3:0] bank_select_register,
  input wire [11:0] stack_frame_pointer,
  input wire ext_op_valid,
  input wire [2:0] ext_op_code,
  output reg opd_valid,
  output reg [11:0] opd_addr,
  output reg opd_indexed,
  output reg opd_is_access,
  output reg opd_to_file,
  output reg opd_banked,
  output reg ext_enabled,
  output reg ext_op_accept,
  output reg ext_op_reject,
  output reg [7:0] ext_op_sel,
  output wire ready
);

  // ****************************************************************
  // Strap synchroniser
  // ****************************************************************
  // The strap is a pin from outside the clock domain, so it passes two
  // flip-flops before the mode logic reads it. They carry no reset:
  // reset is held for several cycles, which lets the level settle
  // before it is caught, and only the second stage is ever read.
  reg strap_meta;
  reg strap_sync;

  always @(posedge core_clk) begin
    strap_meta <= ext_set_strap;
    strap_sync <= strap_meta;
  end

  // ****************************************************************
  // Mode state
  // ****************************************************************
  // The strap is caught once after reset release, so the operand
  // mode and the new instructions can never disagree mid-run.
  localparam ST_WAIT = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;
  reg next_ext_enabled;

  always @* begin
    next_state = state;
    next_ext_enabled = ext_enabled;
    case (state)
      ST_WAIT: begin
        next_state = ST_RUN;
        next_ext_enabled = strap_sync;
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_WAIT;
        next_ext_enabled = `IOD_RST_EXT_ON;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_WAIT;
      ext_enabled <= `IOD_RST_EXT_ON;
    end else begin
      state <= next_state;
      ext_enabled <= next_ext_enabled;
    end
  end

  // Requests seen before the strap is caught are ignored, so the
  // first operand that is taken already sees the final mode and the
  // extended group can never be accepted in the wrong mode.
  assign ready = (state == ST_RUN);

  // ****************************************************************
  // Operand address
  // ****************************************************************
  wire [11:0] gen_addr;
  wire gen_indexed;
  wire gen_is_access;
  wire take_opd;

  // Only instructions that carry the access bit are reinterpreted;
  // the condition is the same for all of them.
  assign take_opd = ready && dec_valid && dec_has_access;

  iod_addr_gen u_addr_gen (
    .ext_on(ext_enabled),
    .access_sel(access_sel),
    .file_field(file_field),
    .bank_select_register(bank_select_register),
    .stack_frame_pointer(stack_frame_pointer),
    .addr(gen_addr),
    .indexed(gen_indexed),
    .is_access(gen_is_access)
  );

  reg next_opd_valid;
  reg [11:0] next_opd_addr;
  reg next_opd_indexed;
  reg next_opd_is_access;
  reg next_opd_to_file;
  reg next_opd_banked;

  // Fields hold between takes, so the memory side may still use them
  // after the valid pulse has gone.
  always @* begin
    next_opd_valid = take_opd;
    next_opd_addr = opd_addr;
    next_opd_indexed = opd_indexed;
    next_opd_is_access = opd_is_access;
    next_opd_to_file = opd_to_file;
    next_opd_banked = opd_banked;
    if (take_opd) begin
      next_opd_addr = gen_addr;
      next_opd_indexed = gen_indexed;
      next_opd_is_access = gen_is_access;
      next_opd_banked = access_sel;
      next_opd_to_file = dest_sel;
    end
  end

  // ****************************************************************
  // Operand registers
  // ****************************************************************

  always @(posedge core_clk) begin
    if (sys_rst) begin
      opd_valid <= 1'b0;
      opd_addr <= `IOD_RST_ADDR;
      opd_indexed <= 1'b0;
      opd_is_access <= 1'b0;
      opd_to_file <= 1'b0;
      opd_banked <= 1'b0;
    end else begin
      opd_valid <= next_opd_valid;
      opd_addr <= next_opd_addr;
      opd_indexed <= next_opd_indexed;
      opd_is_access <= next_opd_is_access;
      opd_to_file <= next_opd_to_file;
      opd_banked <= next_opd_banked;
    end
  end

  // ****************************************************************
  // Extended instruction gate
  // ****************************************************************
  // The eight added instructions exist only while the extension is on;
  // otherwise they are refused and the core treats them as no-ops.
  function [7:0] ext_onehot;
    input [2:0] code;
    begin
      ext_onehot = 8'h01 << code;
    end
  endfunction

  wire take_ext;
  assign take_ext = ready && ext_op_valid;

  reg next_ext_op_accept;
  reg next_ext_op_reject;
  reg [7:0] next_ext_op_sel;

  // A refused instruction leaves the select at zero, so no unit fires.
  always @* begin
    next_ext_op_accept = take_ext && ext_enabled;
    next_ext_op_reject = take_ext && !ext_enabled;
    next_ext_op_sel = `IOD_RST_SEL;
    if (take_ext && ext_enabled) begin
      next_ext_op_sel = ext_onehot(ext_op_code);
    end
  end

  // ****************************************************************
  // Extended instruction registers
  // ****************************************************************

  always @(posedge core_clk) begin
    if (sys_rst) begin
      ext_op_accept <= 1'b0;
      ext_op_reject <= 1'b0;
      ext_op_sel <= `IOD_RST_SEL;
    end else begin
      ext_op_accept <= next_ext_op_accept;
      ext_op_reject <= next_ext_op_reject;
      ext_op_sel <= next_ext_op_sel;
    end
  end

endmodule // iod_operand_decode
`default_nettype wire

// ===== iod_checker.sv
// Purpose: Port assertions for the operand decoder.
// Assumes: One clock, synchronous reset.
// Notes: Bound below the module.
`timescale 1ns/1ps
`default_nettype none
module iod_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ready,
  input wire logic dec_valid,
  input wire logic dec_has_access,
  input wire logic access_sel,
  input wire logic dest_sel,
  input wire logic ext_op_valid,
  input wire logic ext_enabled,
  input wire logic opd_valid,
  input wire logic opd_indexed,
  input wire logic opd_to_file,
  input wire logic opd_banked,
  input wire logic opd_is_access,
  input wire logic ext_op_accept,
  input wire logic ext_op_reject,
  input wire logic [7:0] file_field,
  input wire logic [7:0] ext_op_sel,
  input wire logic [3:0] bank_select_register,
  input wire logic [11:0] stack_frame_pointer,
  input wire logic [11:0] opd_addr,
  input wire logic [2:0] ext_op_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_tk; ready && dec_valid && dec_has_access; endsequence
  sequence s_lo; s_tk ##0 (!access_sel && file_field <= 8'h5F); endsequence
  sequence s_x; ready && ext_op_valid; endsequence
  property p_idx; s_lo ##0 ext_enabled |=> opd_indexed &&
    opd_addr == $past(stack_frame_pointer + file_field); endproperty
  a_idx: assert property (p_idx) else $error("indexed address");
  property p_zero; s_lo ##0 (!ext_enabled || stack_frame_pointer == 12'h000)
    |=> opd_addr == {4'h0, $past(file_field)}; endproperty
  a_zero: assert property (p_zero) else $error("low access");
  property p_hi; s_tk ##0 (!access_sel && file_field > 8'h5F) |=>
    !opd_indexed && opd_is_access && opd_addr == {4'hF, $past(file_field)};
  endproperty
  a_hi: assert property (p_hi) else $error("high access");
  property p_bank; s_tk ##0 access_sel |=> opd_banked && opd_addr ==
    {$past(bank_select_register), $past(file_field)}; endproperty
  a_bank: assert property (p_bank) else $error("banked address");
  property p_dest; s_tk |=> opd_valid && opd_to_file == $past(dest_sel);
  endproperty
  a_dest: assert property (p_dest) else $error("destination bit");
  property p_idle; !(ready && dec_valid && dec_has_access) |=> !opd_valid;
  endproperty
  a_idle: assert property (p_idle) else $error("stray valid");
  property p_acc; s_x ##0 ext_enabled |=> ext_op_accept &&
    ext_op_sel == 8'h01 << $past(ext_op_code); endproperty
  a_acc: assert property (p_acc) else $error("accept");
  property p_rej; s_x ##0 !ext_enabled |=> ext_op_reject && !ext_op_accept
    && ext_op_sel == 8'h00; endproperty
  a_rej: assert property (p_rej) else $error("reject");
endmodule // iod_checker
bind iod_operand_decode iod_checker chk_u (
  .core_clk(core_clk), .sys_rst(sys_rst), .ready(ready),
  .dec_valid(dec_valid), .dec_has_access(dec_has_access),
  .access_sel(access_sel), .dest_sel(dest_sel),
  .ext_op_valid(ext_op_valid), .ext_enabled(ext_enabled),
  .opd_valid(opd_valid), .opd_indexed(opd_indexed),
  .opd_to_file(opd_to_file), .opd_banked(opd_banked),
  .opd_is_access(opd_is_access), .ext_op_accept(ext_op_accept),
  .ext_op_reject(ext_op_reject), .file_field(file_field),
  .ext_op_sel(ext_op_sel), .bank_select_register(bank_select_register),
  .stack_frame_pointer(stack_frame_pointer), .opd_addr(opd_addr),
  .ext_op_code(ext_op_code)
);
`default_nettype wire

// ===== iod_mem_model.sv
// Purpose: Data memory stand-in on the operand address.
// Assumes: Read data follows each valid address.
// Notes: Idle cycles toggle the data so stale values never look valid.
`timescale 1ns/1ps
`default_nettype none
module iod_mem_model (
  input wire logic core_clk,
  input wire logic opd_valid,
  input wire logic [11:0] opd_addr,
  output logic [7:0] rdata
);
  always @(posedge core_clk) begin
    if (opd_valid) rdata <= opd_addr[7:0] ^ {opd_addr[11:8], 4'hA};
    else rdata <= ~rdata;
  end
endmodule // iod_mem_model
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for iod_operand_decode.
// Assumes: Inputs change at the falling edge.
// Notes: Runs once with the extension off and once with it on.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 0, sys_rst = 1, ext_set_strap = 0, dec_valid = 0;
  logic dec_has_access = 0, access_sel = 0, dest_sel = 0, ext_op_valid = 0;
  logic [7:0] file_field = 8'h00, ext_op_sel, rdata;
  logic [3:0] bank_select_register = 4'h0;
  logic [11:0] stack_frame_pointer = 12'h000, opd_addr;
  logic [2:0] ext_op_code = 3'h0;
  logic opd_valid, opd_indexed, opd_is_access, opd_to_file, opd_banked;
  logic ext_enabled, ext_op_accept, ext_op_reject, ready;
  int n_fail = 0, cmp_count = 0, e, i, r, pv;
  always #5 core_clk = ~core_clk;
  iod_operand_decode dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .ext_set_strap(ext_set_strap),
    .dec_valid(dec_valid), .dec_has_access(dec_has_access),
    .file_field(file_field), .access_sel(access_sel), .dest_sel(dest_sel),
    .bank_select_register(bank_select_register),
    .stack_frame_pointer(stack_frame_pointer),
    .ext_op_valid(ext_op_valid), .ext_op_code(ext_op_code),
    .opd_valid(opd_valid), .opd_addr(opd_addr), .opd_indexed(opd_indexed),
    .opd_is_access(opd_is_access), .opd_to_file(opd_to_file),
    .opd_banked(opd_banked), .ext_enabled(ext_enabled),
    .ext_op_accept(ext_op_accept), .ext_op_reject(ext_op_reject),
    .ext_op_sel(ext_op_sel), .ready(ready)
  );
  iod_mem_model mem_u (.core_clk, .opd_valid, .opd_addr, .rdata);
  task automatic chk(string s, logic [23:0] x, logic [23:0] y);
    cmp_count++;
    if (y !== x) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic rst(logic s);
    sys_rst = 1;
    ext_set_strap = s;
    e = s;
    pv = -1;
    repeat (6) @(negedge core_clk);
    sys_rst = 0;
    repeat (2) @(negedge core_clk);
    chk("ready", {ready, ext_enabled}, {1'b1, s});
  endtask
  task automatic op(logic h);
    int f, a, x, ix;
    f = i < 4 ? 94 + i : $urandom % 256;
    a = $urandom % 2;
    dec_valid = 1;
    dec_has_access = h;
    file_field = f[7:0];
    access_sel = a[0];
    dest_sel = 1'($urandom);
    bank_select_register = 4'($urandom);
    stack_frame_pointer = i % 4 ? 12'($urandom) : 12'h000;
    ix = !a && e && f <= 95;
    x = a ? bank_select_register * 256 + f : ix ?
      (stack_frame_pointer + f) % 4096 : f <= 95 ? f : 3840 + f;
    @(negedge core_clk);
    if (pv >= 0) chk("rdata", pv[7:0] ^ {pv[11:8], 4'hA}, rdata);
    if (h) chk("opd", {1'b1, ix[0], !ix[0] && !a[0], a[0], dest_sel,
      x[11:0]}, {opd_valid, opd_indexed, opd_is_access, opd_banked,
      opd_to_file, opd_addr});
    else chk("idle", 24'h0, {23'h0, opd_valid});
    pv = h ? x : -1;
  endtask
  task automatic xop(int k);
    ext_op_valid = 1;
    ext_op_code = k[2:0];
    @(negedge core_clk);
    chk("ext", {e[0], !e[0], e ? 8'h01 << k : 8'h00},
      {ext_op_accept, ext_op_reject, ext_op_sel});
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    r = $urandom(55);
    for (int m = 0; m < 2; m++) begin
      rst(m[0]);
      for (i = 0; i < 40; i++) op(i % 9 != 8);
      dec_valid = 0;
      for (i = 0; i < 8; i++) xop(i);
      ext_op_valid = 0;
      $display("test with extension %0d done", m);
    end
    test_done;
  end
  initial begin
    #100000;
    n_fail++;
    test_done;
  end
endmodule // testbench
`default_nettype wire
